// ---- test/cto_monitor.sv ----
// port checker for the timeout counter
`timescale 1ns/1ns
`default_nettype none

// ==========
// checker
module cto_monitor (
    // clock and reset
    input wire logic        CLOCK,
    input wire logic        RST_B,
    // register port
    input wire logic [7:0]  ADDR,
    input wire logic [31:0] WDATA,
    input wire logic        WR,
    input wire logic        RD,
    input wire logic [31:0] RDATA,
    // controller state
    input wire logic        INIT_MODE,
    input wire logic        CONFIG_CHANGE_EN,
    input wire logic        BIT_TICK,
    // events
    input wire logic        TIMEOUT_OCCURRED_FLAG,
    input wire logic        IRQ
);
    default clocking cb @(posedge CLOCK); endclocking
    default disable iff (!RST_B);

    sequence s_cfg_rd;
        RD && ADDR == 8'h28;
    endsequence
    sequence s_lock_wr;
        WR && ADDR == 8'h28 && !(INIT_MODE && CONFIG_CHANGE_EN);
    endsequence

    a_idle_rdata: assert property (!RD |=> RDATA == 32'h0)
        else $error("read data not zero when idle");
    a_cfg_reserved: assert property (s_cfg_rd |=> RDATA[15:3] == 13'h0)
        else $error("config reserved bits not zero");
    a_val_reserved: assert property (RD && ADDR == 8'h2C |=> RDATA[31:16] == 16'h0)
        else $error("value reserved bits not zero");
    a_unmapped_zero: assert property (RD && !(ADDR inside {8'h28, 8'h2C, 8'h30, 8'h34})
        |=> RDATA == 32'h0)
        else $error("unmapped read not zero");
    a_flag_single: assert property (TIMEOUT_OCCURRED_FLAG |=> !TIMEOUT_OCCURRED_FLAG)
        else $error("timeout flag longer than one cycle");
    a_flag_tick: assert property (TIMEOUT_OCCURRED_FLAG |-> $past(BIT_TICK))
        else $error("timeout flag without a bit tick");
    a_mask_irq: assert property (WR && ADDR == 8'h34 && !WDATA[0] |=> !IRQ)
        else $error("irq high with mask cleared");
    a_cfg_locked: assert property (s_cfg_rd ##1 s_lock_wr ##1 s_cfg_rd
        |=> RDATA == $past(RDATA, 2))
        else $error("locked config write took effect");
endmodule

`default_nettype wire

// ---- test/cto_top_test.sv ----
// register level testbench for the timeout counter
`timescale 1ns/1ns
`default_nettype none

// ==========
// bench
module cto_top_test;
    logic        CLOCK = 1'b0;
    logic        RST_B = 1'b0;
    logic [7:0]  ADDR = 8'h00;
    logic [31:0] WDATA = 32'h0;
    logic        WR = 1'b0;
    logic        RD = 1'b0;
    logic [31:0] RDATA;
    logic        INIT_MODE = 1'b0;
    logic        CONFIG_CHANGE_EN = 1'b0;
    logic        BIT_TICK = 1'b1;
    logic        tick_slow = 1'b0;
    logic [3:0]  BIT_TIME_PRESCALER = 4'h0;
    logic [2:0]  fifo_empty = 3'h7;
    logic        TIMEOUT_OCCURRED_FLAG;
    logic        IRQ;
    int          miscompares = 0;
    int          cmp_count = 0;
    int          cycles = 0;
    int          flags = 0;

    cto_top u_cto_top (.CLOCK, .RST_B, .ADDR, .WDATA, .WR, .RD, .RDATA,
        .INIT_MODE, .CONFIG_CHANGE_EN, .BIT_TICK, .BIT_TIME_PRESCALER,
        .TX_EVENT_EMPTY(fifo_empty[0]), .RX_FIFO0_EMPTY(fifo_empty[1]),
        .RX_FIFO1_EMPTY(fifo_empty[2]), .TIMEOUT_OCCURRED_FLAG, .IRQ);

    always #25 CLOCK = ~CLOCK;

    // bit ticks every other cycle when asked, so units and clocks differ
    always @(posedge CLOCK) begin
        BIT_TICK <= tick_slow ? ~BIT_TICK : 1'b1;
    end

    // a hang ends the run as a failure
    always @(posedge CLOCK) begin
        cycles++;
        if (TIMEOUT_OCCURRED_FLAG === 1'b1) flags++;
        if (cycles == 3000) begin
            miscompares++;
            summarize();
        end
    end

    task automatic summarize();
        $display("checks %0d bad %0d", cmp_count, miscompares);
        if (miscompares == 0 && cmp_count > 0) begin
            $display("ALL TESTS PASSED");
        end else begin
            $display("TESTS FAILED");
        end
        $finish;
    endtask

    task automatic cmp(input string nm, input logic [31:0] exp, input logic [31:0] got);
        cmp_count++;
        if (got !== exp) begin
            miscompares++;
            $display("BAD %s exp %h got %h", nm, exp, got);
        end
    endtask

    task automatic wr(input logic [7:0] a, input logic [31:0] d);
        @(posedge CLOCK);
        WR <= 1'b1;
        ADDR <= a;
        WDATA <= d;
        @(posedge CLOCK);
        WR <= 1'b0;
    endtask

    task automatic chk(input string nm, input logic [7:0] a, input logic [31:0] exp);
        @(posedge CLOCK);
        RD <= 1'b1;
        ADDR <= a;
        @(posedge CLOCK);
        RD <= 1'b0;
        #1 cmp(nm, exp, RDATA);
        @(posedge CLOCK);
    endtask

    // edges from now until irq rises
    task automatic expire(input string nm, input int exp);
        int n;
        n = 0;
        #1;
        while (IRQ !== 1'b1 && n < 200) begin
            @(posedge CLOCK);
            #1;
            n++;
        end
        cmp(nm, exp, n);
    endtask

    initial begin
        int s;
        repeat (20) @(posedge CLOCK);
        RST_B <= 1'b1;
        repeat (23) @(posedge CLOCK);
        chk("cfg", 8'h28, 32'hFFFF0000);
        chk("val", 8'h2C, 32'h0000FFFF);
        chk("sts", 8'h30, 32'h0);
        chk("msk", 8'h34, 32'h0);
        chk("map", 8'h40, 32'h0);
        $display("test reset done");
        wr(8'h28, 32'h0002FFF9);
        CONFIG_CHANGE_EN <= 1'b1;
        wr(8'h28, 32'h0002FFF9);
        chk("lock", 8'h28, 32'hFFFF0000);
        @(posedge CLOCK);
        RD <= 1'b1;
        @(posedge CLOCK);
        RD <= 1'b0;
        WR <= 1'b1;
        @(posedge CLOCK);
        WR <= 1'b0;
        RD <= 1'b1;
        @(posedge CLOCK);
        RD <= 1'b0;
        #1 cmp("lock2", 32'hFFFF0000, RDATA);
        @(posedge CLOCK);
        INIT_MODE <= 1'b1;
        wr(8'h28, 32'h0002FFF9);
        chk("cfg2", 8'h28, 32'h00020001);
        $display("test config done");
        wr(8'h34, 32'h1);
        wr(8'h2C, 32'h0);
        expire("p0", 2);
        chk("zero", 8'h2C, 32'h0);
        cmp("flag", 32'h1, flags);
        wr(8'h34, 32'h0);
        chk("sts1", 8'h30, 32'h1);
        wr(8'h30, 32'h1);
        chk("sts0", 8'h30, 32'h0);
        wr(8'h34, 32'h1);
        BIT_TIME_PRESCALER <= 4'h3;
        wr(8'h2C, 32'h0);
        expire("p3", 8);
        wr(8'h30, 32'h1);
        BIT_TIME_PRESCALER <= 4'h1;
        tick_slow <= 1'b1;
        wr(8'h2C, 32'h0);
        expire("slow", 7);
        wr(8'h30, 32'h1);
        BIT_TIME_PRESCALER <= 4'h0;
        tick_slow <= 1'b0;
        $display("test continuous done");
        for (s = 1; s < 4; s++) begin
            fifo_empty <= 3'h7;
            wr(8'h28, 32'h00030001 | (32'(s) << 1));
            repeat (5) @(posedge CLOCK);
            chk("hold", 8'h2C, 32'h3);
            fifo_empty <= 3'h7 & ~(3'h1 << (s - 1));
            expire("fifo", 3);
            wr(8'h2C, 32'h0);
            chk("nowr", 8'h2C, 32'h0);
            fifo_empty <= 3'h7;
            wr(8'h30, 32'h1);
            chk("pre", 8'h2C, 32'h3);
        end
        $display("test fifo done");
        summarize();
    end
endmodule

bind cto_top cto_monitor u_cto_monitor (.CLOCK, .RST_B, .ADDR, .WDATA, .WR, .RD,
    .RDATA, .INIT_MODE, .CONFIG_CHANGE_EN, .BIT_TICK, .TIMEOUT_OCCURRED_FLAG, .IRQ);

`default_nettype wire

// ---- verilog/cto_pkg.sv ----
// constants for the timeout down-counter block
package cto_pkg;

    // ==============================================================
    // register map, byte addresses
    localparam logic [7:0] ADDR_TIMEOUT_CONFIG = 8'h28;
    localparam logic [7:0] ADDR_TIMEOUT_VALUE  = 8'h2C;
    localparam logic [7:0] ADDR_IRQ_STATUS     = 8'h30;
    localparam logic [7:0] ADDR_IRQ_MASK       = 8'h34;

    // ==============================================================
    // timeout_config fields, hardware bit numbers (bit 0 is lsb)
    localparam int PERIOD_LSB = 16;
    localparam int PERIOD_MSB = 31;
    localparam int SELECT_LSB = 1;
    localparam int SELECT_MSB = 2;
    localparam int ENABLE_BIT = 0;

    // timeout_value field
    localparam int COUNT_LSB = 0;
    localparam int COUNT_MSB = 15;

    // status and mask layout
    localparam int IRQ_TIMEOUT_BIT = 0;

    // ==============================================================
    // reset values
    localparam logic [15:0] PERIOD_RESET = 16'hFFFF;
    localparam logic [15:0] COUNT_RESET  = 16'hFFFF;
    localparam logic        ENABLE_RESET = 1'b0;
    localparam logic [0:0]  MASK_RESET   = 1'h0;

    // ==============================================================
    // timeout_select codes
    typedef enum logic [1:0] {
        SEL_CONTINUOUS = 2'h0,
        SEL_TX_EVENT   = 2'h1,
        SEL_RX_FIFO0   = 2'h2,
        SEL_RX_FIFO1   = 2'h3
    } cto_select_type;

    // counter state, one-hot
    typedef enum logic [1:0] {
        ST_RUN  = 2'h1,
        ST_STOP = 2'h2
    } cto_state_type;

endpackage

// ---- verilog/cto_prescale.sv ----
// bit-time prescaler producing one time-unit pulse per (prescaler + 1) bit ticks
`timescale 1ns/1ns
`default_nettype none

module cto_prescale (
    // clock and reset
    input  wire logic       clk,
    input  wire logic       rst_n,
    // control
    input  wire logic       run,
    input  wire logic [3:0] bit_time_prescaler,
    input  wire logic       bit_tick,
    // result
    output logic            unit_tick
);

    logic [3:0] phase_q;
    logic [3:0] phase_d;

    // ==============================================================
    // phase counter
    always_comb begin
        phase_d   = phase_q;
        unit_tick = 1'b0;
        if (!run) begin
            // restart phase so each run begins on a full unit
            phase_d = 4'h0;
        end else if (bit_tick) begin
            if (phase_q >= bit_time_prescaler) begin
                phase_d   = 4'h0;
                unit_tick = 1'b1;
            end else begin
                phase_d = phase_q + 4'h1;
            end
        end
    end

    always_ff @(posedge clk or negedge rst_n) begin
        if (!rst_n) begin
            phase_q <= 4'h0;
        end else begin
            phase_q <= phase_d;
        end
    end

endmodule

`default_nettype wire

// ---- verilog/cto_top.sv ----
// timeout down-counter with register port and interrupt
// ==============================================================
// Summary of operation
// - period field loads counter on every preset
// - select: continuous, tx event, rx0, rx1
// - continuous: value write reloads, keeps counting
// - fifo modes: empty fifo holds period
// - fifo modes: count once element stored
// - count only while enable bit set
// - value decrements once per time unit
// - zero sets flag, stops until restart
// - reserved bits read zero, ignore writes
// - period, select, enable are write protected
// - unit is prescaler plus one bit times
//
// Strobed register access was decided locally.
`timescale 1ns/1ns
`default_nettype none

module cto_top (
    // clock and reset
    input  wire logic        CLOCK,
    input  wire logic        RST_B,
    // register port
    input  wire logic [7:0]  ADDR,
    input  wire logic [31:0] WDATA,
    input  wire logic        WR,
    input  wire logic        RD,
    output logic [31:0]      RDATA,
    // controller state
    input  wire logic        INIT_MODE,
    input  wire logic        CONFIG_CHANGE_EN,
    input  wire logic        BIT_TICK,
    input  wire logic [3:0]  BIT_TIME_PRESCALER,
    // fifo fill state
    input  wire logic        TX_EVENT_EMPTY,
    input  wire logic        RX_FIFO0_EMPTY,
    input  wire logic        RX_FIFO1_EMPTY,
    // events
    output logic             TIMEOUT_OCCURRED_FLAG,
    output logic             IRQ
);

    // ==============================================================
    // reset release
    logic rst_meta_q;
    logic rst_sync_q;
    logic rst_n;

    always_ff @(posedge CLOCK or negedge RST_B) begin
        if (!RST_B) begin
            rst_meta_q <= 1'b0;
            rst_sync_q <= 1'b0;
        end else begin
            rst_meta_q <= 1'b1;
            rst_sync_q <= rst_meta_q;
        end
    end

    assign rst_n = rst_sync_q;

    // ==============================================================
    // address decode
    logic hit_config;
    logic hit_value;
    logic hit_status;
    logic hit_mask;
    logic cfg_unlocked;

    always_comb begin
        hit_config = 1'b0;
        hit_value  = 1'b0;
        hit_status = 1'b0;
        hit_mask   = 1'b0;
        if (ADDR == cto_pkg::ADDR_TIMEOUT_CONFIG) begin
            hit_config = 1'b1;
        end else if (ADDR == cto_pkg::ADDR_TIMEOUT_VALUE) begin
            hit_value = 1'b1;
        end else if (ADDR == cto_pkg::ADDR_IRQ_STATUS) begin
            hit_status = 1'b1;
        end else if (ADDR == cto_pkg::ADDR_IRQ_MASK) begin
            hit_mask = 1'b1;
        end
    end

    assign cfg_unlocked = INIT_MODE && CONFIG_CHANGE_EN;

    // ==============================================================
    // configuration register
    logic [15:0]                  period_q;
    logic [15:0]                  period_d;
    cto_pkg::cto_select_type      select_q;
    cto_pkg::cto_select_type      select_d;
    logic                         enable_q;
    logic                         enable_d;

    always_comb begin
        period_d = period_q;
        select_d = select_q;
        enable_d = enable_q;
        if (WR && hit_config && cfg_unlocked) begin
            period_d = WDATA[cto_pkg::PERIOD_MSB:cto_pkg::PERIOD_LSB];
            select_d = cto_pkg::cto_select_type'(
                WDATA[cto_pkg::SELECT_MSB:cto_pkg::SELECT_LSB]);
            enable_d = WDATA[cto_pkg::ENABLE_BIT];
        end
    end

    always_ff @(posedge CLOCK or negedge rst_n) begin
        if (!rst_n) begin
            period_q <= cto_pkg::PERIOD_RESET;
            select_q <= cto_pkg::SEL_CONTINUOUS;
            enable_q <= cto_pkg::ENABLE_RESET;
        end else begin
            period_q <= period_d;
            select_q <= select_d;
            enable_q <= enable_d;
        end
    end

    // ==============================================================
    // fifo selection
    logic fifo_mode;
    logic fifo_empty;

    always_comb begin
        fifo_mode  = 1'b1;
        fifo_empty = 1'b0;
        case (select_q)
            cto_pkg::SEL_CONTINUOUS: begin
                fifo_mode = 1'b0;
            end
            cto_pkg::SEL_TX_EVENT: begin
                fifo_empty = TX_EVENT_EMPTY;
            end
            cto_pkg::SEL_RX_FIFO0: begin
                fifo_empty = RX_FIFO0_EMPTY;
            end
            default: begin
                fifo_empty = RX_FIFO1_EMPTY;
            end
        endcase
    end

    // ==============================================================
    // down-counter
    logic [15:0]             count_q;
    logic [15:0]             count_d;
    cto_pkg::cto_state_type  state_q;
    cto_pkg::cto_state_type  state_d;
    logic                    expire;
    logic                    counting;
    logic                    unit_tick;

    // the prescaler phase only advances while a decrement is actually possible
    assign counting = enable_q && (state_q == cto_pkg::ST_RUN)
                      && !(fifo_mode && fifo_empty);

    cto_prescale u_prescale (
        .clk                (CLOCK),
        .rst_n              (rst_n),
        .run                (counting),
        .bit_time_prescaler (BIT_TIME_PRESCALER),
        .bit_tick           (BIT_TICK),
        .unit_tick          (unit_tick)
    );

    always_comb begin
        count_d = count_q;
        state_d = state_q;
        expire  = 1'b0;
        if (fifo_mode && fifo_empty) begin
            // empty fifo keeps the counter preset and armed
            count_d = period_q;
            state_d = cto_pkg::ST_RUN;
        end else if (!fifo_mode && WR && hit_value) begin
            count_d = period_q;
            state_d = cto_pkg::ST_RUN;
        end else begin
            case (state_q)
                cto_pkg::ST_RUN: begin
                    // in fifo modes this is reached once the fifo holds data
                    if (counting && unit_tick) begin
                        if (count_q <= 16'h0001) begin
                            count_d = 16'h0000;
                            state_d = cto_pkg::ST_STOP;
                            expire  = 1'b1;
                        end else begin
                            count_d = count_q - 16'h0001;
                        end
                    end
                end
                default: begin
                    state_d = cto_pkg::ST_STOP;
                end
            endcase
        end
    end

    always_ff @(posedge CLOCK or negedge rst_n) begin
        if (!rst_n) begin
            count_q <= cto_pkg::COUNT_RESET;
            state_q <= cto_pkg::ST_RUN;
        end else begin
            count_q <= count_d;
            state_q <= state_d;
        end
    end

    // ==============================================================
    // interrupt status and mask
    logic status_q;
    logic status_d;
    logic mask_q;
    logic mask_d;
    logic pulse_q;

    always_comb begin
        status_d = status_q;
        mask_d   = mask_q;
        if (WR && hit_status && WDATA[cto_pkg::IRQ_TIMEOUT_BIT]) begin
            status_d = 1'b0;
        end
        // a new timeout in the clearing cycle survives the clear
        if (expire) begin
            status_d = 1'b1;
        end
        if (WR && hit_mask) begin
            mask_d = WDATA[cto_pkg::IRQ_TIMEOUT_BIT];
        end
    end

    always_ff @(posedge CLOCK or negedge rst_n) begin
        if (!rst_n) begin
            status_q <= 1'b0;
            mask_q   <= cto_pkg::MASK_RESET[0];
            pulse_q  <= 1'b0;
        end else begin
            status_q <= status_d;
            mask_q   <= mask_d;
            pulse_q  <= expire;
        end
    end

    assign TIMEOUT_OCCURRED_FLAG = pulse_q;
    assign IRQ                   = status_q && mask_q;

    // ==============================================================
    // read data, one cycle after the strobe
    logic [31:0] rdata_q;
    logic [31:0] rdata_d;

    always_comb begin
        rdata_d = 32'h0000_0000;
        if (RD) begin
            if (hit_config) begin
                rdata_d[cto_pkg::PERIOD_MSB:cto_pkg::PERIOD_LSB] = period_q;
                rdata_d[cto_pkg::SELECT_MSB:cto_pkg::SELECT_LSB] = select_q;
                rdata_d[cto_pkg::ENABLE_BIT]                     = enable_q;
            end else if (hit_value) begin
                rdata_d[cto_pkg::COUNT_MSB:cto_pkg::COUNT_LSB] = count_q;
            end else if (hit_status) begin
                rdata_d[cto_pkg::IRQ_TIMEOUT_BIT] = status_q;
            end else if (hit_mask) begin
                rdata_d[cto_pkg::IRQ_TIMEOUT_BIT] = mask_q;
            end
        end
    end

    always_ff @(posedge CLOCK or negedge rst_n) begin
        if (!rst_n) begin
            rdata_q <= 32'h0000_0000;
        end else begin
            rdata_q <= rdata_d;
        end
    end

    assign RDATA = rdata_q;

endmodule

`default_nettype wire
